// [lsens_host_model.sv]
// Purpose: Behavioural host that drives the serial register link
// Assumes: Link clock idles low; device samples on rising edges
// Notes:   Data line is inverted after a frame so no stale bit lingers

`timescale 1ns/1ps
`default_nettype none

module lsens_host_model #(
  parameter int HALF_NS = 32
) (
  // Serial link
  output logic link_sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  // ==========================================================
  // Idle link: clock stands still low between frames
  initial begin
    link_sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // One frame; bits change after falls, read bits taken at rises
  task automatic xfer(input logic [1:0] mode, input logic [5:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] word;
    word = {mode, addr, wdata};
    rdata = 8'h00;
    cs_n_out = 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      mosi_out = word[i];
      #(HALF_NS);
      if (i < 8) rdata[i] = miso_in;
      link_sclk_out = 1'b1;
      #(HALF_NS);
      link_sclk_out = 1'b0;
    end
    #(HALF_NS);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    // Gap covers the select-high time and the write crossing
    #(10 * HALF_NS);
  endtask
endmodule

`default_nettype wire

// [lsens_pkg.sv]
// Purpose: Shared constants of the lightning sensor register bank
// Assumes: Eight-bit registers at word indices 0x0 to 0x8
// Notes:   Cause codes and strike targets are plain defaults

package lsens_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [5:0] ADDR_GAIN_PWD = 6'h00;
  localparam logic [5:0] ADDR_NOISE_WD = 6'h01;
  localparam logic [5:0] ADDR_STATS = 6'h02;
  localparam logic [5:0] ADDR_TUNE_CAUSE = 6'h03;
  localparam logic [5:0] ADDR_ENERGY_LOW = 6'h04;
  localparam logic [5:0] ADDR_ENERGY_MID = 6'h05;
  localparam logic [5:0] ADDR_ENERGY_HIGH = 6'h06;
  localparam logic [5:0] ADDR_DISTANCE = 6'h07;
  localparam logic [5:0] ADDR_OSC_SELECT = 6'h08;
  localparam int NUM_REGS = 9;

  // ==========================================================
  // Field positions
  localparam int POS_PWD = 0;
  localparam int POS_GAIN = 1;
  localparam int POS_NOISE = 4;
  localparam int POS_CLR_STAT = 6;
  localparam int POS_MIN_STRIKE = 4;
  localparam int POS_DIV = 6;
  localparam int POS_MASK = 5;
  localparam int POS_SHOW_ANT = 7;
  localparam int POS_SHOW_FAST = 6;
  localparam int POS_SHOW_SLOW = 5;

  // ==========================================================
  // Reset values
  localparam logic [4:0] RST_GAIN = 5'h12;
  localparam logic [2:0] RST_NOISE = 3'h2;
  localparam logic [3:0] RST_WD_THRESH = 4'h1;
  localparam logic [3:0] RST_SPIKE = 4'h2;
  localparam logic [1:0] RST_MIN_STRIKE = 2'h0;
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic [3:0] RST_CAUSE = 4'h0;

  // ==========================================================
  // Interrupt cause codes
  localparam logic [3:0] CAUSE_NOISE = 4'h1;
  localparam logic [3:0] CAUSE_DISTURBER = 4'h4;
  localparam logic [3:0] CAUSE_LIGHTNING = 4'h8;

  // ==========================================================
  // Serial frame: two mode bits, six address bits, one data byte
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_READ = 2'h1;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HEADER_BITS = 5'h08;

  // Strikes needed for each minimum count setting
  localparam logic [3:0] STRIKES_0 = 4'h1;
  localparam logic [3:0] STRIKES_1 = 4'h2;
  localparam logic [3:0] STRIKES_2 = 4'h4;
  localparam logic [3:0] STRIKES_3 = 4'h8;

  // Antenna divider: ratio is two to the power (base plus field)
  localparam int DIV_BASE_LOG2 = 4;

  // Sensor operating modes
  typedef enum logic [1:0] {
    LSENS_POWER_DOWN,
    LSENS_LISTEN,
    LSENS_VERIFY
  } lsens_mode_e;

endpackage

// [lsens_regs.sv]
// Purpose: Control and status register bank of the lightning sensor
// Assumes: Serial host port on its own clock, detector logic on mclk_in
// Notes:   Read data comes from a shadow that freezes while select is low

`timescale 1ns/1ps
`default_nettype none

module lsens_regs
  import lsens_pkg::*;
(
  // System clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Serial host link
  input wire logic link_sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // Detector side
  input wire logic [3:0] antenna_activity_in,
  input wire logic noise_high_in,
  input wire logic disturber_in,
  input wire logic lightning_in,
  input wire logic [20:0] energy_in,
  input wire logic [5:0] distance_in,
  // Oscillators
  input wire logic antenna_oscillator_in,
  input wire logic fast_rc_oscillator_in,
  input wire logic slow_rc_oscillator_in,
  // Controls and interrupt pin
  output logic power_down_out,
  output logic [1:0] mode_out,
  output logic irq_out
);

  // ==========================================================
  // Serial link domain (link_sclk_in)
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic [15:0] word;
  logic [5:0] wr_addr_reg, wr_addr_next, rd_addr_reg, rd_addr_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic wr_tog_reg, wr_tog_next, rd_cause_tog_reg, rd_cause_tog_next;
  logic is_read_reg, is_read_next;
  logic [7:0] out_shift_reg, out_shift_next;
  logic oe_reg, oe_next;
  logic [7:0] shadow_reg [NUM_REGS];

  assign word = {shift_reg[14:0], mosi_in};

  // Frame decode; select high clears the counter since sclk may stop
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    shift_next = word;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    wr_tog_next = wr_tog_reg;
    rd_addr_next = rd_addr_reg;
    is_read_next = is_read_reg;
    rd_cause_tog_next = rd_cause_tog_reg;
    if (bit_cnt_reg != FRAME_BITS) begin
      bit_cnt_next = bit_cnt_reg + 5'h01;
    end
    if (bit_cnt_reg == HEADER_BITS - 5'h01) begin
      rd_addr_next = word[5:0];
      is_read_next = (word[7:6] == MODE_READ);
      if (word[7:6] == MODE_READ && word[5:0] == ADDR_TUNE_CAUSE) begin
        rd_cause_tog_next = ~rd_cause_tog_reg;
      end
    end
    if (bit_cnt_reg == FRAME_BITS - 5'h01 && word[15:14] == MODE_WRITE) begin
      wr_addr_next = word[13:8];
      wr_data_next = word[7:0];
      wr_tog_next = ~wr_tog_reg;
    end
  end

  // Frame position, cleared whenever the host deselects
  always_ff @(posedge link_sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      is_read_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      is_read_reg <= is_read_next;
    end
  end

  // Captured words and toggles persist between frames
  always_ff @(posedge link_sclk_in or posedge srst_in) begin
    if (srst_in) begin
      wr_addr_reg <= 6'h00;
      wr_data_reg <= 8'h00;
      wr_tog_reg <= 1'b0;
      rd_addr_reg <= 6'h00;
      rd_cause_tog_reg <= 1'b0;
    end else begin
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      wr_tog_reg <= wr_tog_next;
      rd_addr_reg <= rd_addr_next;
      rd_cause_tog_reg <= rd_cause_tog_next;
    end
  end

  // Read data leaves on falling edges; shadow is frozen during the frame
  always_comb begin
    out_shift_next = {out_shift_reg[6:0], 1'b0};
    oe_next = oe_reg;
    if (bit_cnt_reg == HEADER_BITS && is_read_reg) begin
      out_shift_next = (rd_addr_reg < NUM_REGS[5:0]) ? shadow_reg[rd_addr_reg[3:0]] : 8'h00;
      oe_next = 1'b1;
    end
  end

  always_ff @(negedge link_sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_shift_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      out_shift_reg <= out_shift_next;
      oe_reg <= oe_next;
    end
  end

  assign miso_out = out_shift_reg[7];
  assign miso_oe_out = oe_reg;

  // ==========================================================
  // Crossings into mclk_in
  logic [5:0] sync_out;
  logic cs_idle, wr_tog_s, rd_tog_s, ant_s, fast_s, slow_s;
  logic wr_seen_reg, rd_seen_reg;
  logic wr_pulse, rd_pulse;

  lsens_sync3 #(.WIDTH(6)) u_sync (
    .clk_in(mclk_in),
    .srst_in(srst_in),
    .async_in({cs_n_in, wr_tog_reg, rd_cause_tog_reg, antenna_oscillator_in,
               fast_rc_oscillator_in, slow_rc_oscillator_in}),
    .sync_out(sync_out)
  );

  assign {cs_idle, wr_tog_s, rd_tog_s, ant_s, fast_s, slow_s} = sync_out;
  assign wr_pulse = wr_tog_s ^ wr_seen_reg;
  assign rd_pulse = rd_tog_s ^ rd_seen_reg;

  // ==========================================================
  // Register state (mclk_in)
  logic [4:0] gain_reg, gain_next;
  logic pwd_reg, pwd_next;
  logic [2:0] noise_reg, noise_next;
  logic [3:0] wd_thresh_reg, wd_thresh_next;
  logic clr_stat_reg, clr_stat_next;
  logic [1:0] min_strike_reg, min_strike_next;
  logic [3:0] spike_reg, spike_next;
  logic [1:0] div_reg, div_next;
  logic mask_reg, mask_next;
  logic [3:0] cause_reg, cause_next;
  logic [20:0] energy_reg, energy_next;
  logic [5:0] distance_reg, distance_next;
  logic [2:0] show_reg, show_next;
  logic [3:0] strikes_reg, strikes_next;
  logic irq_level_reg, irq_level_next;
  lsens_mode_e mode_reg, mode_next;

  // Strike target for the minimum count setting
  function automatic logic [3:0] strikes_needed(input logic [1:0] sel);
    unique case (sel)
      2'h0: strikes_needed = STRIKES_0;
      2'h1: strikes_needed = STRIKES_1;
      2'h2: strikes_needed = STRIKES_2;
      2'h3: strikes_needed = STRIKES_3;
    endcase
  endfunction

  // Host writes, mode machine and event capture
  always_comb begin
    gain_next = gain_reg;
    pwd_next = pwd_reg;
    noise_next = noise_reg;
    wd_thresh_next = wd_thresh_reg;
    clr_stat_next = clr_stat_reg;
    min_strike_next = min_strike_reg;
    spike_next = spike_reg;
    div_next = div_reg;
    mask_next = mask_reg;
    show_next = show_reg;
    cause_next = cause_reg;
    energy_next = energy_reg;
    distance_next = distance_reg;
    strikes_next = strikes_reg;
    mode_next = mode_reg;
    irq_level_next = irq_level_reg & ~rd_pulse;
    if (wr_pulse) begin
      unique case (wr_addr_reg)
        ADDR_GAIN_PWD: begin
          gain_next = wr_data_reg[POS_GAIN +: 5];
          pwd_next = wr_data_reg[POS_PWD];
        end
        ADDR_NOISE_WD: begin
          noise_next = wr_data_reg[POS_NOISE +: 3];
          wd_thresh_next = wr_data_reg[3:0];
        end
        ADDR_STATS: begin
          clr_stat_next = wr_data_reg[POS_CLR_STAT];
          min_strike_next = wr_data_reg[POS_MIN_STRIKE +: 2];
          spike_next = wr_data_reg[3:0];
          if (clr_stat_reg && !wr_data_reg[POS_CLR_STAT]) begin
            strikes_next = 4'h0;
          end
        end
        ADDR_TUNE_CAUSE: begin
          div_next = wr_data_reg[POS_DIV +: 2];
          mask_next = wr_data_reg[POS_MASK];
        end
        ADDR_OSC_SELECT: begin
          show_next = wr_data_reg[POS_SHOW_SLOW +: 3];
        end
        default: begin
        end
      endcase
    end
    unique case (mode_reg)
      LSENS_POWER_DOWN: begin
        if (!pwd_reg) begin
          mode_next = LSENS_LISTEN;
        end
      end
      LSENS_LISTEN: begin
        if (pwd_reg) begin
          mode_next = LSENS_POWER_DOWN;
        end else if (antenna_activity_in > wd_thresh_reg) begin
          mode_next = LSENS_VERIFY;
        end else if (noise_high_in) begin
          cause_next = CAUSE_NOISE;
          irq_level_next = 1'b1;
        end
      end
      LSENS_VERIFY: begin
        if (pwd_reg) begin
          mode_next = LSENS_POWER_DOWN;
        end else if (disturber_in) begin
          mode_next = LSENS_LISTEN;
          if (!mask_reg) begin
            cause_next = CAUSE_DISTURBER;
            irq_level_next = 1'b1;
          end
        end else if (lightning_in) begin
          mode_next = LSENS_LISTEN;
          if (strikes_reg != 4'hF) begin
            strikes_next = strikes_reg + 4'h1;
          end
          if ({1'b0, strikes_reg} + 5'h01 >= {1'b0, strikes_needed(min_strike_reg)}) begin
            energy_next = energy_in;
            distance_next = distance_in;
            cause_next = CAUSE_LIGHTNING;
            irq_level_next = 1'b1;
          end
        end
      end
      default: begin
        mode_next = LSENS_POWER_DOWN;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      gain_reg <= RST_GAIN;
      pwd_reg <= 1'b0;
      noise_reg <= RST_NOISE;
      wd_thresh_reg <= RST_WD_THRESH;
      clr_stat_reg <= 1'b1;
      min_strike_reg <= RST_MIN_STRIKE;
      spike_reg <= RST_SPIKE;
      div_reg <= RST_DIV;
      mask_reg <= 1'b0;
      show_reg <= 3'h0;
      cause_reg <= RST_CAUSE;
      energy_reg <= 21'h000000;
      distance_reg <= 6'h00;
      strikes_reg <= 4'h0;
      irq_level_reg <= 1'b0;
      mode_reg <= LSENS_LISTEN;
      wr_seen_reg <= wr_tog_s;
      rd_seen_reg <= rd_tog_s;
    end else begin
      gain_reg <= gain_next;
      pwd_reg <= pwd_next;
      noise_reg <= noise_next;
      wd_thresh_reg <= wd_thresh_next;
      clr_stat_reg <= clr_stat_next;
      min_strike_reg <= min_strike_next;
      spike_reg <= spike_next;
      div_reg <= div_next;
      mask_reg <= mask_next;
      show_reg <= show_next;
      cause_reg <= cause_next;
      energy_reg <= energy_next;
      distance_reg <= distance_next;
      strikes_reg <= strikes_next;
      irq_level_reg <= irq_level_next;
      mode_reg <= mode_next;
      wr_seen_reg <= wr_tog_s;
      rd_seen_reg <= rd_tog_s;
    end
  end

  // ==========================================================
  // Read shadow, refreshed only while the host is deselected
  always_ff @(posedge mclk_in) begin
    if (cs_idle) begin
      shadow_reg[0] <= {2'h0, gain_reg, pwd_reg};
      shadow_reg[1] <= {1'b0, noise_reg, wd_thresh_reg};
      shadow_reg[2] <= {1'b1, clr_stat_reg, min_strike_reg, spike_reg};
      shadow_reg[3] <= {div_reg, mask_reg, 1'b0, cause_reg};
      shadow_reg[4] <= energy_reg[7:0];
      shadow_reg[5] <= energy_reg[15:8];
      shadow_reg[6] <= {3'h0, energy_reg[20:16]};
      shadow_reg[7] <= {2'h0, distance_reg};
      shadow_reg[8] <= {show_reg, 5'h00};
    end
  end

  // ==========================================================
  // Antenna divider and interrupt pin mux
  logic [7:0] div_cnt_reg, div_cnt_next;
  logic ant_prev_reg, ant_div_reg, ant_div_next;
  logic irq_pin_reg, irq_pin_next, pwd_out_reg;

  // Divided antenna clock toggles every half ratio of rising edges
  always_comb begin
    div_cnt_next = div_cnt_reg;
    ant_div_next = ant_div_reg;
    if (ant_s && !ant_prev_reg) begin
      div_cnt_next = div_cnt_reg + 8'h01;
      if (div_cnt_reg[DIV_BASE_LOG2 - 1 + div_reg] ^ div_cnt_next[DIV_BASE_LOG2 - 1 + div_reg]) begin
        ant_div_next = ~ant_div_reg;
      end
    end
  end

  // Antenna display wins over fast RC, which wins over slow RC
  always_comb begin
    if (show_reg[2]) begin
      irq_pin_next = ant_div_reg;
    end else if (show_reg[1]) begin
      irq_pin_next = fast_s;
    end else if (show_reg[0]) begin
      irq_pin_next = slow_s;
    end else begin
      irq_pin_next = irq_level_reg;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      div_cnt_reg <= 8'h00;
      ant_prev_reg <= 1'b0;
      ant_div_reg <= 1'b0;
      irq_pin_reg <= 1'b0;
      pwd_out_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      ant_prev_reg <= ant_s;
      ant_div_reg <= ant_div_next;
      irq_pin_reg <= irq_pin_next;
      pwd_out_reg <= (mode_next == LSENS_POWER_DOWN);
    end
  end

  assign irq_out = irq_pin_reg;
  assign power_down_out = pwd_out_reg;
  assign mode_out = mode_reg;

  // ==========================================================
  // Checks
  property p_verify_entry;
    @(posedge mclk_in) disable iff (srst_in)
    (mode_reg == LSENS_LISTEN && !pwd_reg && antenna_activity_in > wd_thresh_reg) |=> mode_reg == LSENS_VERIFY;
  endproperty
  a_verify_entry: assert property (p_verify_entry) else $error("verify not entered");

  property p_disturber_irq;
    @(posedge mclk_in) disable iff (srst_in)
    (mode_reg == LSENS_VERIFY && !pwd_reg && disturber_in && !mask_reg)
      |=> (cause_reg == CAUSE_DISTURBER && irq_level_reg && mode_reg == LSENS_LISTEN);
  endproperty
  a_disturber_irq: assert property (p_disturber_irq) else $error("disturber irq missing");

  property p_disturber_masked;
    @(posedge mclk_in) disable iff (srst_in)
    (mode_reg == LSENS_VERIFY && !pwd_reg && disturber_in && mask_reg && !irq_level_reg)
      |=> !irq_level_reg;
  endproperty
  a_disturber_masked: assert property (p_disturber_masked) else $error("masked disturber raised irq");

  property p_lightning;
    @(posedge mclk_in) disable iff (srst_in)
    (mode_reg == LSENS_VERIFY && !pwd_reg && !disturber_in && lightning_in && strikes_needed(min_strike_reg) == 4'h1)
      |=> (cause_reg == CAUSE_LIGHTNING && distance_reg == $past(distance_in) && energy_reg == $past(energy_in));
  endproperty
  a_lightning: assert property (p_lightning) else $error("lightning not recorded");

  property p_power_down;
    @(posedge mclk_in) disable iff (srst_in)
    pwd_reg && mode_reg != LSENS_POWER_DOWN |=> mode_reg == LSENS_POWER_DOWN ##1 power_down_out;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down not entered");

  property p_wake;
    @(posedge mclk_in) disable iff (srst_in)
    (mode_reg == LSENS_POWER_DOWN && !pwd_reg) |=> mode_reg == LSENS_LISTEN;
  endproperty
  a_wake: assert property (p_wake) else $error("no return to listening");

  property p_show_fast;
    @(posedge mclk_in) disable iff (srst_in)
    (show_reg == 3'h2) [*2] |-> irq_out == $past(fast_s);
  endproperty
  a_show_fast: assert property (p_show_fast) else $error("fast rc not on irq");

  property p_show_slow;
    @(posedge mclk_in) disable iff (srst_in)
    (show_reg == 3'h1) [*2] |-> irq_out == $past(slow_s);
  endproperty
  a_show_slow: assert property (p_show_slow) else $error("slow rc not on irq");

  property p_show_ant;
    @(posedge mclk_in) disable iff (srst_in)
    show_reg[2] [*2] |-> irq_out == $past(ant_div_reg);
  endproperty
  a_show_ant: assert property (p_show_ant) else $error("antenna osc not on irq");

  property p_reset_vals;
    @(posedge mclk_in) $past(srst_in)
      |-> (cause_reg == 4'h0 && energy_reg == 21'h000000 && div_reg == 2'h0 && min_strike_reg == 2'h0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

endmodule

`default_nettype wire

// [lsens_sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_in
// Notes:   Output moves only when stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module lsens_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [WIDTH-1:0] out_next;

  // ==========================================================
  // Filter: a bit updates only once stages two and three agree
  always_comb begin
    out_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & out_reg);
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench of the sensor register bank
// Assumes: Detector inputs change at falling mclk edges
// Notes:   Link traffic comes from the host model on its own clock

`timescale 1ns/1ps
`default_nettype none

module tb;
  import lsens_pkg::*;
  logic mclk, srst, sclk, cs_n, mosi, miso, miso_oe;
  logic noise, disturber, lightning, power_down, irq;
  logic [3:0] activity;
  logic [20:0] energy;
  logic [5:0] distance;
  logic [2:0] osc;
  logic [1:0] mode;
  logic oe_seen;
  int checks, n_mismatch;

  // ==========================================================
  // Device and host
  lsens_regs i_dut (.mclk_in(mclk), .srst_in(srst), .link_sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .antenna_activity_in(activity),
    .noise_high_in(noise), .disturber_in(disturber), .lightning_in(lightning),
    .energy_in(energy), .distance_in(distance), .antenna_oscillator_in(osc[2]),
    .fast_rc_oscillator_in(osc[1]), .slow_rc_oscillator_in(osc[0]),
    .power_down_out(power_down), .mode_out(mode), .irq_out(irq));
  lsens_host_model i_host (.link_sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso));

  // Output enable as seen at the last rising link edge of a frame
  always @(posedge sclk) oe_seen <= miso_oe;

  // System clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.xfer(MODE_READ, a, 8'h00, d);
    chk(d, exp);
    chk({7'h00, oe_seen}, 8'h01);
    chk({7'h00, miso_oe}, 8'h00);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] d;
    i_host.xfer(MODE_WRITE, a, v, d);
    chk({7'h00, oe_seen}, 8'h00);
  endtask
  // Watchdog crosses threshold, then one classified event
  task automatic strike(input logic is_light);
    cyc(1);
    activity = 4'h2;
    cyc(3);
    chk({6'h00, mode}, 8'h02);
    activity = 4'h0;
    lightning = is_light;
    disturber = ~is_light;
    cyc(1);
    lightning = 1'b0;
    disturber = 1'b0;
    cyc(4);
    chk({6'h00, mode}, 8'h01);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] rv [9] = '{8'h24, 8'h21, 8'hC2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rd(6'(i), rv[i]);
  endtask
  task automatic t_fields();
    wr(ADDR_TUNE_CAUSE, 8'hFF);
    rd(ADDR_TUNE_CAUSE, 8'hE0);
    wr(ADDR_STATS, 8'h30);
    rd(ADDR_STATS, 8'hB0);
    wr(ADDR_ENERGY_LOW, 8'hFF);
    rd(ADDR_ENERGY_LOW, 8'h00);
    rd(6'h09, 8'h00);
    wr(ADDR_TUNE_CAUSE, 8'h00);
    wr(ADDR_STATS, 8'h02);
  endtask
  task automatic t_osc();
    // Antenna is shown divided: field 0 gives 16 edges per period
    wr(ADDR_OSC_SELECT, 8'h80);
    cyc(1);
    for (int n = 1; n <= 16; n++) begin
      osc = 3'b100;
      cyc(4);
      osc = 3'b000;
      cyc(4);
      chk({7'h00, irq}, (n >= 8 && n < 16) ? 8'h01 : 8'h00);
    end
    for (int i = 1; i < 3; i++) begin
      wr(ADDR_OSC_SELECT, 8'h80 >> i);
      cyc(1);
      osc = 3'b100 >> i;
      cyc(8);
      chk({7'h00, irq}, 8'h01);
      osc = ~(3'b100 >> i);
      cyc(8);
      chk({7'h00, irq}, 8'h00);
      osc = 3'b000;
    end
    wr(ADDR_OSC_SELECT, 8'h00);
  endtask
  task automatic t_events();
    cyc(1);
    activity = 4'h1;
    cyc(4);
    chk({6'h00, mode}, 8'h01);
    energy = 21'h1ABCDE;
    distance = 6'h15;
    strike(1'b1);
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_DISTANCE, 8'h15);
    rd(ADDR_ENERGY_LOW, 8'hDE);
    rd(ADDR_ENERGY_MID, 8'hBC);
    rd(ADDR_ENERGY_HIGH, 8'h1A);
    rd(ADDR_TUNE_CAUSE, 8'h08);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_TUNE_CAUSE, 8'h20);
    strike(1'b0);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_TUNE_CAUSE, 8'h00);
    strike(1'b0);
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_TUNE_CAUSE, 8'h04);
    cyc(1);
    noise = 1'b1;
    cyc(1);
    noise = 1'b0;
    cyc(3);
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_TUNE_CAUSE, 8'h01);
  endtask
  task automatic t_pwd();
    wr(ADDR_GAIN_PWD, 8'h25);
    cyc(1);
    chk({7'h00, power_down}, 8'h01);
    activity = 4'hF;
    cyc(4);
    chk({6'h00, mode}, 8'h00);
    activity = 4'h0;
    wr(ADDR_GAIN_PWD, 8'h24);
    cyc(1);
    chk({6'h00, mode}, 8'h01);
    chk({7'h00, power_down}, 8'h00);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    noise = 1'b0;
    disturber = 1'b0;
    lightning = 1'b0;
    activity = 4'h0;
    energy = 21'h000000;
    distance = 6'h00;
    osc = 3'b000;
    checks = 0;
    n_mismatch = 0;
    cyc(4);
    srst = 1'b0;
    cyc(8);
    t_reset();
    t_fields();
    t_osc();
    t_events();
    t_pwd();
    conclude();
  end

  // Hang guard, well beyond the roughly 50 us of traffic
  initial begin
    #500000;
    n_mismatch++;
    conclude();
  end
endmodule

`default_nettype wire
